// ### logic/smrc_pkg.sv
// Shared constants and types for the memory card reset sequencer
package smrc_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned HOLD_NS       = 800;
	localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SANITY_US     = 100;
	localparam int unsigned SANITY_CYC    = (SANITY_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned MONITOR_US    = 200;
	localparam int unsigned MONITOR_CYC   = (MONITOR_US * 1000) / CLK_PERIOD_NS;

	// ==========================================================
	// Widths and reset values
	localparam int unsigned           CNT_W        = 8;
	localparam int unsigned           TMR_W        = 12;
	localparam logic [CNT_W-1:0]      HOLD_CNT_RST = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0]      CLK_ON_CNT   = CNT_W'(HOLD_CYC / 2);
	localparam logic [TMR_W-1:0]      SANITY_LOAD  = TMR_W'(SANITY_CYC - 1);
	localparam logic [TMR_W-1:0]      MONITOR_LOAD = TMR_W'(MONITOR_CYC - 1);

	// ==========================================================
	// Reset levels
	typedef enum logic [1:0] {
		SMRC_LVL_NONE,
		SMRC_LVL_PWRUP,
		SMRC_LVL_HARD,
		SMRC_LVL_SOFT
	} smrc_level_t;

endpackage : smrc_pkg

// ### logic/smrc_tmr_if.sv
// Link between the sequencer and one of its watchdog timers
`timescale 1ns/1ps
interface smrc_tmr_if;
	logic kick;
	logic run;
	logic expire;
	modport owner (output kick, output run, input expire);
	modport timer (input kick, input run, output expire);
endinterface : smrc_tmr_if

// ### logic/smrc_timer.sv
// Watchdog down-counter used for the sanity and monitor timers
`timescale 1ns/1ps
module smrc_timer #(
	parameter int unsigned           W    = smrc_pkg::TMR_W,
	parameter logic [W-1:0]          LOAD = W'(smrc_pkg::SANITY_CYC - 1)
) (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	input  wire logic  clk_en,
	smrc_tmr_if.timer  tif
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         exp;
	} smrc_tmr_t;

	smrc_tmr_t q_ff;
	smrc_tmr_t nxt_q;

	// ==========================================================
	// Count down
	always_comb begin
		nxt_q     = q_ff;
		nxt_q.exp = 1'b0;
		if (tif.kick || !tif.run) begin
			nxt_q.cnt = LOAD;
		end else if (q_ff.cnt == '0) begin
			nxt_q.exp = 1'b1;
			nxt_q.cnt = LOAD;
		end else begin
			nxt_q.cnt = q_ff.cnt - W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= '{cnt: LOAD, exp: 1'b0};
		end else if (clk_en) begin
			q_ff <= nxt_q;
		end
	end

	assign tif.expire = q_ff.exp;

	// ==========================================================
	// Checks
	property p_tmr_kick;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && tif.kick) |=> !tif.expire;
	endproperty
	a_tmr_kick: assert property (p_tmr_kick) else $error("timer expired right after a kick");

	property p_tmr_zero;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && tif.run && !tif.kick && q_ff.cnt == '0) |=> tif.expire && q_ff.cnt == LOAD;
	endproperty
	a_tmr_zero: assert property (p_tmr_zero) else $error("timer did not expire at zero");

endmodule : smrc_timer

// ### logic/smrc_reset_ctrl.sv
// Reset and self-test sequencer of the shared memory card
//
// What this block does
// - Three reset levels: power-up, hard and soft, applied to card components.
// - Hard reset from sanity expiry, control write, parity/protocol error, monitor expiry.
// - Soft reset only from sanity expiry or a control register write.
// - Sanity expiry or control write picks hard or soft from select and program bits.
// - Sanity timer sits in ownership controller; separate monitor timer watches test controller.
// - Structure tests are started as part of power-up and hard reset handling, not after soft reset.
// - Memory self-test is started by the ownership controller, not the test units.
// - Internal faults go to the test units on a dedicated line, not I2C.
// - Memories and controller run on the main clock distributed through reset control.
`timescale 1ns/1ps
module smrc_reset_ctrl (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic         ctl_reg_wr,
	input  wire logic         soft_reset_select_bit,
	input  wire logic         reset_program_bit,
	input  wire logic         parity_err,
	input  wire logic         protocol_err,
	input  wire logic         sanity_kick,
	input  wire logic         test_ctrl_alive,
	input  wire logic         internal_fault,
	input  wire logic         struct_test_done,
	input  wire logic         bist_done,
	output logic              hard_rst_n,
	output logic              soft_rst_n,
	output logic              struct_test_start,
	output logic              bist_start,
	output logic              fault_to_test,
	output logic              comp_clk_en,
	output logic [1:0]        reset_level,
	output logic              sanity_expired,
	output logic              monitor_expired
);

	// ==========================================================
	// State
	typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_TEST} smrc_state_t;

	typedef struct packed {
		smrc_state_t                     st;
		smrc_pkg::smrc_level_t           lvl;
		logic [smrc_pkg::CNT_W-1:0]      cnt;
		logic                            hard_rst_n;
		logic                            soft_rst_n;
		logic                            test_start;
		logic                            bist_start;
		logic                            fault;
		logic                            clk_on;
	} smrc_reg_t;

	localparam smrc_reg_t RST_VAL = '{
		st:         ST_HOLD,
		lvl:        smrc_pkg::SMRC_LVL_PWRUP,
		cnt:        smrc_pkg::HOLD_CNT_RST,
		hard_rst_n: 1'b0,
		soft_rst_n: 1'b0,
		test_start: 1'b0,
		bist_start: 1'b0,
		fault:      1'b0,
		clk_on:     1'b0
	};

	smrc_reg_t q_ff;
	smrc_reg_t nxt_q;

	// ==========================================================
	// Timers
	smrc_tmr_if sanity_if ();
	smrc_tmr_if monitor_if ();

	// Timers stop while components are held, so no stale expiry follows a reset
	assign sanity_if.kick  = sanity_kick;
	assign sanity_if.run   = (q_ff.st != ST_HOLD);
	assign monitor_if.kick = test_ctrl_alive;
	assign monitor_if.run  = (q_ff.st != ST_HOLD);

	smrc_timer #(
		.W    (smrc_pkg::TMR_W),
		.LOAD (smrc_pkg::SANITY_LOAD)
	) u_sanity (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.tif    (sanity_if.timer)
	);

	smrc_timer #(
		.W    (smrc_pkg::TMR_W),
		.LOAD (smrc_pkg::MONITOR_LOAD)
	) u_monitor (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.tif    (monitor_if.timer)
	);

	// ==========================================================
	// Request decode
	logic soft_choice;
	logic shared_trig;
	logic hard_req;
	logic soft_req;

	assign soft_choice = soft_reset_select_bit && !reset_program_bit;
	assign shared_trig = sanity_if.expire || ctl_reg_wr;
	assign hard_req    = (shared_trig && !soft_choice) || parity_err || protocol_err
	                     || monitor_if.expire;
	assign soft_req    = shared_trig && soft_choice;

	// Entering hold: hard takes both reset lines, soft only its own
	function automatic smrc_reg_t enter_rst(input smrc_reg_t r, input logic hard);
		smrc_reg_t o;
		o            = r;
		o.st         = ST_HOLD;
		o.lvl        = hard ? smrc_pkg::SMRC_LVL_HARD : smrc_pkg::SMRC_LVL_SOFT;
		o.cnt        = smrc_pkg::HOLD_CNT_RST;
		o.soft_rst_n = 1'b0;
		o.hard_rst_n = !hard;
		return o;
	endfunction : enter_rst

	// ==========================================================
	// Sequencer
	always_comb begin
		nxt_q            = q_ff;
		nxt_q.test_start = 1'b0;
		nxt_q.bist_start = 1'b0;
		nxt_q.fault      = internal_fault;
		unique case (q_ff.st)
			ST_IDLE: begin
				if (hard_req) begin
					nxt_q = enter_rst(nxt_q, 1'b1);
				end else if (soft_req) begin
					nxt_q = enter_rst(nxt_q, 1'b0);
				end
			end
			ST_HOLD: begin
				if (hard_req && q_ff.lvl == smrc_pkg::SMRC_LVL_SOFT) begin
					nxt_q = enter_rst(nxt_q, 1'b1);
				end else if (q_ff.cnt == '0) begin
					// Release all lines on one edge so nothing wakes half-reset
					nxt_q.hard_rst_n = 1'b1;
					nxt_q.soft_rst_n = 1'b1;
					nxt_q.clk_on     = 1'b1;
					if (q_ff.lvl == smrc_pkg::SMRC_LVL_SOFT) begin
						nxt_q.st = ST_IDLE;
					end else begin
						nxt_q.test_start = 1'b1;
						nxt_q.bist_start = 1'b1;
						nxt_q.st         = ST_TEST;
					end
				end else begin
					nxt_q.cnt = q_ff.cnt - smrc_pkg::CNT_W'(1);
					// Clocks start mid-hold so parts see edges while still in reset
					if (q_ff.cnt == smrc_pkg::CLK_ON_CNT) begin
						nxt_q.clk_on = 1'b1;
					end
				end
			end
			ST_TEST: begin
				if (hard_req) begin
					nxt_q = enter_rst(nxt_q, 1'b1);
				end else if (struct_test_done && bist_done) begin
					nxt_q.st = ST_IDLE;
				end
			end
			default: begin
				nxt_q = RST_VAL;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= RST_VAL;
		end else if (clk_en) begin
			q_ff <= nxt_q;
		end
	end

	// ==========================================================
	// Outputs
	assign hard_rst_n        = q_ff.hard_rst_n;
	assign soft_rst_n        = q_ff.soft_rst_n;
	assign struct_test_start = q_ff.test_start;
	assign bist_start        = q_ff.bist_start;
	assign fault_to_test     = q_ff.fault;
	assign comp_clk_en       = q_ff.clk_on;
	assign reset_level       = q_ff.lvl;
	assign sanity_expired    = sanity_if.expire;
	assign monitor_expired   = monitor_if.expire;

	// ==========================================================
	// Checks
	logic [7:0] low_cnt_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_ff <= 8'h00;
		end else if (soft_rst_n) begin
			low_cnt_ff <= 8'h00;
		end else if (clk_en && low_cnt_ff != 8'hFF) begin
			low_cnt_ff <= low_cnt_ff + 8'h01;
		end
	end

	sequence s_hard_entry;
		clk_en && q_ff.st == ST_IDLE && hard_req;
	endsequence

	sequence s_hard_held;
		!hard_rst_n && !soft_rst_n [*2];
	endsequence

	property p_hard_start;
		@(posedge mclk) disable iff (!rst_n)
		s_hard_entry |=> s_hard_held;
	endproperty
	a_hard_start: assert property (p_hard_start) else $error("hard trigger did not reset");

	property p_soft_start;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && q_ff.st == ST_IDLE && soft_req && !hard_req) |=> (!soft_rst_n && hard_rst_n);
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("soft trigger wrong");

	property p_select;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && q_ff.st == ST_IDLE && ctl_reg_wr && !hard_req)
			|=> reset_level == smrc_pkg::SMRC_LVL_SOFT;
	endproperty
	a_select: assert property (p_select) else $error("select bits ignored");

	property p_prio;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && q_ff.st == ST_IDLE && hard_req && soft_req) |=> reset_level == smrc_pkg::SMRC_LVL_HARD;
	endproperty
	a_prio: assert property (p_prio) else $error("soft won over hard");

	property p_hold_len;
		@(posedge mclk) disable iff (!rst_n)
		$rose(soft_rst_n) |-> (low_cnt_ff >= 8'(smrc_pkg::HOLD_CYC) && hard_rst_n);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("reset released too early");

	property p_test_after_hard;
		@(posedge mclk) disable iff (!rst_n)
		($rose(hard_rst_n) && clk_en) |-> (struct_test_start && bist_start) ##1 (!struct_test_start && !bist_start);
	endproperty
	a_test_after_hard: assert property (p_test_after_hard) else $error("tests not started");

	property p_no_test_soft;
		@(posedge mclk) disable iff (!rst_n)
		($rose(soft_rst_n) && $past(hard_rst_n)) |-> !struct_test_start && !bist_start;
	endproperty
	a_no_test_soft: assert property (p_no_test_soft) else $error("tests after soft reset");

	property p_fault;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && internal_fault) |=> fault_to_test;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not forwarded");

	property p_monitor;
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && q_ff.st != ST_HOLD && monitor_if.expire) |=> !hard_rst_n;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor expiry ignored");

	property p_clk_on;
		@(posedge mclk) disable iff (!rst_n)
		$rose(hard_rst_n) |-> $past(comp_clk_en);
	endproperty
	a_clk_on: assert property (p_clk_on) else $error("clock off at release");

endmodule : smrc_reset_ctrl

// ### tb/smrc_test_model.sv
// Behavioural model of the test controller, test master and memory self-test side
`timescale 1ns/1ps
module smrc_test_model (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	input  wire logic  kick_en,
	input  wire logic  alive_en,
	input  wire logic  hard_rst_n,
	input  wire logic  struct_test_start,
	input  wire logic  fault_to_test,
	output logic       struct_test_done,
	output logic       bist_done,
	output logic       sanity_kick,
	output logic       test_ctrl_alive
);
	// ==========================================================
	// Test run and keep-alive
	logic [3:0]  delay_ff;
	int          fault_log;
	// Random run length so the sequencer sees prompt and slow test units
	always @(negedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			delay_ff <= 4'h0;
			struct_test_done <= 1'b0;
			bist_done <= 1'b0;
			sanity_kick <= 1'b0;
			test_ctrl_alive <= 1'b0;
			fault_log <= 0;
		end else begin
			sanity_kick <= kick_en & ~sanity_kick;
			test_ctrl_alive <= alive_en;
			if (!hard_rst_n) begin
				delay_ff <= 4'h0;
				struct_test_done <= 1'b0;
				bist_done <= 1'b0;
			end else if (struct_test_start) begin
				delay_ff <= 4'($urandom_range(9, 1));
			end else if (delay_ff != 4'h0) begin
				delay_ff <= delay_ff - 4'h1;
				struct_test_done <= (delay_ff == 4'h1);
				bist_done <= (delay_ff == 4'h1);
			end
			if (fault_to_test === 1'b1)
				fault_log <= fault_log + 1;
		end
	end
endmodule : smrc_test_model

// ### tb/testbench.sv
// Self-checking bench for the memory card reset sequencer
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals
	logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ctl_reg_wr = 1'b0, sel = 1'b0, prog = 1'b0;
	logic parity_err = 1'b0, protocol_err = 1'b0, internal_fault = 1'b0, kick_en = 1'b1, alive_en = 1'b1;
	logic sanity_kick, test_ctrl_alive, struct_test_done, bist_done, hard_rst_n, soft_rst_n;
	logic struct_test_start, bist_start, fault_to_test, comp_clk_en, sanity_expired, monitor_expired;
	logic [1:0]  reset_level;
	logic [11:0] exp_q[$];
	logic [11:0] got;
	logic [7:0]  low_cnt = 8'h00;
	logic        hlow = 1'b0;
	int          n_mismatch = 0, comparisons = 0, cyc = 0, frz, i;
	always #50 mclk = ~mclk;
	smrc_reset_ctrl i_smrc_reset_ctrl (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ctl_reg_wr(ctl_reg_wr),
		.soft_reset_select_bit(sel), .reset_program_bit(prog), .parity_err(parity_err),
		.protocol_err(protocol_err), .sanity_kick(sanity_kick), .test_ctrl_alive(test_ctrl_alive),
		.internal_fault(internal_fault), .struct_test_done(struct_test_done), .bist_done(bist_done),
		.hard_rst_n(hard_rst_n), .soft_rst_n(soft_rst_n), .struct_test_start(struct_test_start),
		.bist_start(bist_start), .fault_to_test(fault_to_test), .comp_clk_en(comp_clk_en),
		.reset_level(reset_level), .sanity_expired(sanity_expired), .monitor_expired(monitor_expired));
	smrc_test_model i_smrc_test_model (.mclk(mclk), .rst_n(rst_n), .kick_en(kick_en), .alive_en(alive_en),
		.hard_rst_n(hard_rst_n), .struct_test_start(struct_test_start), .fault_to_test(fault_to_test),
		.struct_test_done(struct_test_done), .bist_done(bist_done), .sanity_kick(sanity_kick),
		.test_ctrl_alive(test_ctrl_alive));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic print_verdict;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// Note: {hard line dropped, hold cycles, level, test start, self-test start}
	function automatic logic [11:0] note(input logic [7:0] c, input logic [1:0] l, input logic s);
		return {s, c[6:0], l, s, s};
	endfunction : note
	task automatic wait_idle;
		int k;
		for (k = 0; k < 100 && !(struct_test_done === 1'b1 && soft_rst_n === 1'b1); k++)
			@(negedge mclk);
		chk(12'(k < 100), 12'h001);
		repeat (2) @(negedge mclk);
	endtask : wait_idle
	// Blocking on the falling edge: a ref argument takes no deferred update
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask : pulse
	// ==========================================================
	// Result watcher: a released reset is one result
	always @(negedge mclk) begin
		if (!rst_n) begin
			low_cnt = 8'h00;
			hlow = 1'b0;
		end else if (soft_rst_n !== 1'b1) begin
			low_cnt = low_cnt + 8'h01;
			hlow = hlow | (hard_rst_n !== 1'b1);
		end else if (low_cnt != 8'h00) begin
			got = {hlow, low_cnt[6:0], reset_level, struct_test_start, bist_start};
			if (exp_q.size() == 0)
				chk(got, 12'h000);
			else
				chk(got, exp_q.pop_front());
			low_cnt = 8'h00;
			hlow = 1'b0;
		end
	end
	// Hang guard sized for two long timer waits plus margin
	always @(posedge mclk) begin
		cyc++;
		if (cyc >= 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hF28E9D71));
		exp_q.push_back(note(8'h07, 2'h1, 1'b1));
		repeat (4) @(negedge mclk);
		rst_n <= 1'b1;
		wait_idle();
		chk(12'(comp_clk_en), 12'h001);
		exp_q.push_back(note(8'h08, 2'h2, 1'b1));
		exp_q.push_back(note(8'h08, 2'h2, 1'b1));
		pulse(parity_err);
		// Second hard trigger lands on the first edge of the test phase
		for (i = 0; i < 20 && struct_test_start !== 1'b1; i++)
			@(negedge mclk);
		pulse(protocol_err);
		wait_idle();
		frz = $urandom_range(4, 1);
		exp_q.push_back(note(8'(8 + frz), 2'h2, 1'b1));
		pulse(protocol_err);
		@(negedge mclk);
		clk_en <= 1'b0;
		repeat (frz) @(negedge mclk);
		clk_en <= 1'b1;
		wait_idle();
		for (i = 0; i < 4; i++) begin
			{sel, prog} = 2'(i);
			exp_q.push_back(note(8'h08, (i == 2) ? 2'h3 : 2'h2, i != 2));
			pulse(ctl_reg_wr);
			wait_idle();
		end
		{sel, prog} = 2'b10;
		exp_q.push_back(note(8'h08, 2'h2, 1'b1));
		parity_err <= 1'b1;
		pulse(ctl_reg_wr);
		parity_err <= 1'b0;
		wait_idle();
		// Soft hold upgraded to hard by an error one cycle later
		exp_q.push_back(note(8'h09, 2'h2, 1'b1));
		pulse(ctl_reg_wr);
		pulse(parity_err);
		wait_idle();
		exp_q.push_back(note(8'h08, 2'h3, 1'b0));
		kick_en <= 1'b0;
		for (i = 0; i < 1100 && sanity_expired !== 1'b1; i++)
			@(negedge mclk);
		kick_en <= 1'b1;
		chk(12'(i > 990 && i < 1010), 12'h001);
		wait_idle();
		exp_q.push_back(note(8'h08, 2'h2, 1'b1));
		alive_en <= 1'b0;
		for (i = 0; i < 2100 && monitor_expired !== 1'b1; i++)
			@(negedge mclk);
		alive_en <= 1'b1;
		chk(12'(i > 1990 && i < 2010), 12'h001);
		wait_idle();
		for (i = 0; i < 8; i++) begin
			internal_fault <= 1'($urandom);
			@(negedge mclk);
			chk(12'(fault_to_test), 12'(internal_fault));
		end
		repeat (4) @(negedge mclk);
		chk(12'(exp_q.size()), 12'h000);
		print_verdict();
	end
endmodule : testbench
